// ### dv/tas_host_model.sv
// Behavioural two-wire host that moves whole register words.
module tas_host_model
  import tas_pkg::*;
(
  input wire logic mclk,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic ptr_wr,
  output logic [7:0] ptr_data,
  output logic reg_wr,
  output logic [15:0] reg_wr_data,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero.
  initial
  begin
    {ptr_wr, reg_wr, reg_rd} = 3'h0;
    ptr_data = 8'h00;
    reg_wr_data = 16'h0000;
  end

  // Every access loads the pointer first; idle data is inverted so a
  // stale value can never pass for a fresh one.
  task automatic load_ptr(input logic [7:0] addr);
    @(posedge mclk);
    #1;
    ptr_wr = 1'b1;
    ptr_data = addr;
    @(posedge mclk);
    #1;
    ptr_wr = 1'b0;
    ptr_data = ~addr;
  endtask

  task automatic write_word(input logic [7:0] addr,
    input logic [15:0] data);
    load_ptr(addr);
    reg_wr = 1'b1;
    reg_wr_data = data;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_wr_data = ~data;
  endtask

  // The answer is awaited under a bound; ok stays low on a hang. The
  // answer is looked at just after an edge, where it has settled.
  task automatic read_word(input logic [7:0] addr,
    output logic [15:0] data, output bit ok);
    ok = 1'b0;
    data = 16'h0000;
    load_ptr(addr);
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (rd_valid === 1'b1)
      begin
        data = rd_data;
        ok = 1'b1;
      end
      else
      begin
        @(posedge mclk);
        #1;
      end
    end
  endtask
endmodule

// ### dv/tas_status_alarm_asserts.sv
// Port checker for the thermal alarm status block.
module tas_status_alarm_asserts
  import tas_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_data,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic conv_valid,
  input wire logic [7:0] open_detect,
  input wire logic lock_active,
  input wire logic soft_reset_pulse,
  input wire logic first_alarm_out_n,
  input wire logic second_alarm_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dflt @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] ptr_q;
  logic trig;

  // Shadow pointer; a software reset clears it like the real one.
  always_ff @(posedge mclk)
  begin
    if (sys_rst || soft_reset_pulse)
      ptr_q <= PTR_POR;
    else if (ptr_wr)
      ptr_q <= ptr_data;
  end

  // A trigger write that the lock does not block.
  assign trig = reg_wr && ptr_q == PTR_SOFT_RESET
    && reg_wr_data[RESET_TRIGGER_BIT] && !lock_active;

  property p_rd_answer;
    reg_rd && !soft_reset_pulse |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read request not answered");
  property p_rd_cause;
    rd_valid |-> $past(reg_rd);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without request");
  property p_trig_cause;
    soft_reset_pulse |-> $past(trig);
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("software reset without unlocked trigger");
  property p_trig_fire;
    trig && !soft_reset_pulse |=> soft_reset_pulse;
  endproperty
  a_trig_fire: assert property (p_trig_fire)
    else $error("trigger write did not reset");
  property p_trig_alarm;
    soft_reset_pulse |=> first_alarm_out_n && second_alarm_out_n;
  endproperty
  a_trig_alarm: assert property (p_trig_alarm)
    else $error("alarms not released by software reset");
  property p_reset_reads_zero;
    rd_valid && $past(ptr_q) == PTR_SOFT_RESET |-> rd_data == ZERO_WORD;
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero)
    else $error("reset register read not zero");
  property p_status_low;
    rd_valid && ($past(ptr_q) == PTR_FIRST_STATUS
      || $past(ptr_q) == PTR_SECOND_STATUS) |-> rd_data[6:0] == 7'h00;
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("status reserved bits not zero");
  // A reset in the cycle before the read clears the open flags, so the
  // detector input of that cycle is not what the word shows.
  property p_open_map;
    rd_valid && $past(ptr_q) == PTR_OPEN_STATUS && !$past(sys_rst, 2)
      && !$past(soft_reset_pulse, 2)
      |-> rd_data == {$past(open_detect, 2), 8'h00};
  endproperty
  a_open_map: assert property (p_open_map)
    else $error("open status word wrong");
  property p_alarm_quiet;
    !$past(conv_valid) && !$past(conv_valid, 2) && !$past(soft_reset_pulse)
      |-> $stable(first_alarm_out_n) && $stable(second_alarm_out_n);
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet)
    else $error("alarm moved without a conversion");
endmodule

bind tas_status_alarm tas_status_alarm_asserts u_tas_status_alarm_asserts (
  .mclk(mclk), .sys_rst(sys_rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
  .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd),
  .rd_data(rd_data), .rd_valid(rd_valid), .conv_valid(conv_valid),
  .open_detect(open_detect), .lock_active(lock_active),
  .soft_reset_pulse(soft_reset_pulse),
  .first_alarm_out_n(first_alarm_out_n),
  .second_alarm_out_n(second_alarm_out_n)
);

// ### dv/tas_status_alarm_tb_top.sv
// Self-checking testbench for the thermal alarm status block.
module tas_status_alarm_tb_top
  import tas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, sys_rst, ptr_wr, reg_wr, reg_rd, rd_valid, conv_valid;
  logic lock_active, soft_reset_pulse, first_alarm_out_n, second_alarm_out_n;
  logic [7:0] ptr_data, open_detect;
  logic [15:0] reg_wr_data, rd_data;
  tas_conv_type conv;
  int num_errors, comparisons, pulses, seed, hyst;
  int lim1 [9];
  int lim2 [9];
  bit f1 [9];
  bit f2 [9];

  tas_status_alarm u_tas_status_alarm (
    .mclk(mclk), .sys_rst(sys_rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
    .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd),
    .rd_data(rd_data), .rd_valid(rd_valid), .conv_valid(conv_valid),
    .conv(conv), .open_detect(open_detect), .lock_active(lock_active),
    .soft_reset_pulse(soft_reset_pulse),
    .first_alarm_out_n(first_alarm_out_n),
    .second_alarm_out_n(second_alarm_out_n));
  tas_host_model u_tas_host_model (
    .mclk(mclk), .rd_valid(rd_valid), .rd_data(rd_data), .ptr_wr(ptr_wr),
    .ptr_data(ptr_data), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
    .reg_rd(reg_rd));

  // Free-running 200 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Counting pulses proves that blocked triggers stay silent.
  always @(posedge mclk)
    if (soft_reset_pulse === 1'b1)
      pulses++;

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------------
  function automatic bit next_flag(bit f, int t, int lim);
    return t > lim ? 1'b1 : (t <= lim - hyst ? 1'b0 : f);
  endfunction

  function automatic logic [15:0] status(input bit second);
    logic [15:0] s;
    s = 16'h0000;
    for (int c = 0; c < 9; c++)
      s[7 + c] = second ? f2[c] : f1[c];
    return s;
  endfunction

  function automatic logic [7:0] lim_addr(input int c);
    return c == 0 ? PTR_LOCAL_FIRST_LIMIT
      : 8'(PTR_REMOTE_FIRST_BASE + PTR_REMOTE_STRIDE * (c - 1));
  endfunction

  task automatic model_reset();
    hyst = HYSTERESIS_POR;
    for (int c = 0; c < 9; c++)
    begin
      lim1[c] = FIRST_LIMIT_POR;
      lim2[c] = SECOND_LIMIT_POR;
      f1[c] = 1'b0;
      f2[c] = 1'b0;
    end
  endtask

  task automatic check_alarms();
    bit a1;
    bit a2;
    a1 = 1'b0;
    a2 = 1'b0;
    #1;
    for (int c = 0; c < 9; c++)
    begin
      a1 |= f1[c];
      a2 |= f2[c];
    end
    check_pin(first_alarm_out_n, !a1);
    check_pin(second_alarm_out_n, !a2);
  endtask

  task automatic read_cmp(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    u_tas_host_model.read_word(addr, d, ok);
    if (!ok)
    begin
      num_errors++;
      finish_test();
    end
    check_word(d, exp);
  endtask

  // One stored result; the alarm settles one edge after the flag.
  task automatic convert(input int ch, input int t, input logic [7:0] od);
    @(posedge mclk);
    #1;
    conv_valid = 1'b1;
    conv.chan = ch[3:0];
    conv.temp = t[15:0];
    open_detect = od;
    @(posedge mclk);
    #1;
    conv_valid = 1'b0;
    conv.temp = ~conv.temp;
    if (ch < 9)
    begin
      f1[ch] = next_flag(f1[ch], t, lim1[ch]);
      f2[ch] = next_flag(f2[ch], t, lim2[ch]);
    end
    repeat (2) @(posedge mclk);
  endtask

  // Hang guard.
  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end

  // Main sequence.
  initial
  begin
    int c, t, base;
    logic [7:0] od;
    seed = 56;
    {sys_rst, conv_valid, lock_active} = 3'h4;
    conv = '0;
    open_detect = 8'h00;
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    model_reset();
    read_cmp(PTR_SOFT_RESET, SOFT_RESET_POR);
    read_cmp(PTR_SECOND_STATUS, status(1));
    read_cmp(PTR_OPEN_STATUS, ZERO_WORD);
    read_cmp(8'h10, UNMAPPED_READ_VALUE);
    u_tas_host_model.write_word(PTR_FIRST_STATUS, 16'hFFFF);
    u_tas_host_model.write_word(8'h10, 16'hFFFF);
    read_cmp(PTR_FIRST_STATUS, status(0));
    hyst = ($random(seed) & 32'h03C0) | 32'h0040;
    u_tas_host_model.write_word(PTR_HYSTERESIS, hyst[15:0]);
    read_cmp(PTR_HYSTERESIS, hyst[15:0]);
    for (c = 0; c < 9; c++)
    begin
      lim1[c] = $random(seed) & 32'h3FC0;
      lim2[c] = lim1[c] + 32'h0400;
      u_tas_host_model.write_word(lim_addr(c), lim1[c][15:0]);
      u_tas_host_model.write_word(lim_addr(c) + 8'h01, lim2[c][15:0]);
    end
    read_cmp(lim_addr(8) + 8'h01, lim2[8][15:0]);
    read_cmp(PTR_LOCAL_SECOND_LIMIT, lim2[0][15:0]);
    convert(9, 32'h7000, 8'h00);
    check_alarms();
    for (int n = 0; n < 60; n++)
    begin
      c = {$random(seed)} % 9;
      base = ($random(seed) & 1) ? lim2[c] : lim1[c];
      case (n % 6)
        0: t = base + 1;
        1: t = base;
        2: t = base - hyst;
        3: t = base - hyst + 1;
        4: t = base + ($random(seed) % 512);
        default: t = base - hyst - 1;
      endcase
      od = 8'($random(seed));
      convert(c, t, od);
      check_alarms();
      read_cmp(PTR_FIRST_STATUS, status(0));
      read_cmp(PTR_SECOND_STATUS, status(1));
      read_cmp(PTR_OPEN_STATUS, {od, 8'h00});
    end
    @(posedge mclk);
    #1;
    lock_active = 1'b1;
    u_tas_host_model.write_word(PTR_SOFT_RESET, 16'h8000);
    repeat (3) @(posedge mclk);
    check_word(pulses[15:0], 16'h0000);
    read_cmp(PTR_LOCAL_FIRST_LIMIT, lim1[0][15:0]);
    @(posedge mclk);
    #1;
    lock_active = 1'b0;
    u_tas_host_model.write_word(PTR_SOFT_RESET, 16'h7FFF);
    read_cmp(PTR_SOFT_RESET, ZERO_WORD);
    check_word(pulses[15:0], 16'h0000);
    u_tas_host_model.write_word(PTR_SOFT_RESET, 16'h8000);
    repeat (3) @(posedge mclk);
    check_word(pulses[15:0], 16'h0001);
    model_reset();
    check_alarms();
    read_cmp(PTR_LOCAL_FIRST_LIMIT, FIRST_LIMIT_POR);
    read_cmp(PTR_FIRST_STATUS, status(0));
    finish_test();
  end
endmodule

// ### rtl/tas_limit_cell.sv
// One limit comparator with hysteresis release for a single channel.
module tas_limit_cell
  import tas_pkg::*;
(
  input wire logic mclk,
  input wire logic clear,
  input wire logic update,
  input wire logic [15:0] temp,
  input wire logic [15:0] limit,
  input wire logic [15:0] hysteresis,
  output logic flag
);

  // --------------------------------------------------------------------
  // Signed arithmetic
  // --------------------------------------------------------------------
  // One extra bit keeps limit minus hysteresis from wrapping near the
  // bottom of the range, which would release the flag far too early.
  logic signed [16:0] temp_ext;
  logic signed [16:0] limit_ext;
  logic signed [16:0] release_level;
  logic over;
  logic released;

  assign temp_ext = {temp[15], temp};
  assign limit_ext = {limit[15], limit};
  assign release_level = limit_ext - $signed({1'b0, hysteresis});
  assign over = temp_ext > limit_ext;
  assign released = temp_ext <= release_level;

  // --------------------------------------------------------------------
  // Flag register
  // --------------------------------------------------------------------
  // Apart from clear, the flag only moves when a fresh result for this channel arrives;
  // inside the hysteresis band it holds its last state.
  always_ff @(posedge mclk)
  begin
    if (clear)
    begin
      flag <= 1'b0;
    end
    else if (update)
    begin
      if (over)
      begin
        flag <= 1'b1;
      end
      else if (released)
      begin
        flag <= 1'b0;
      end
    end
  end

endmodule

// ### rtl/tas_status_alarm.sv
// Status, limit comparison, alarm outputs and software reset of the monitor.
module tas_status_alarm
  import tas_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_data,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic conv_valid,
  input wire tas_conv_type conv,
  input wire logic [7:0] open_detect,
  input wire logic lock_active,
  output logic soft_reset_pulse,
  output logic first_alarm_out_n,
  output logic second_alarm_out_n
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Maps a pointer to a limit register: local limits sit just above the
  // hysteresis register, remote limits in one block of eight per channel.
  function automatic tas_limit_sel_type decode_limit(input logic [7:0] ptr);
    tas_limit_sel_type sel;
    logic [7:0] off;
    sel = '0;
    off = ptr - PTR_REMOTE_FIRST_BASE;
    if (ptr == PTR_LOCAL_FIRST_LIMIT || ptr == PTR_LOCAL_SECOND_LIMIT)
    begin
      sel.hit = 1'b1;
      sel.second = (ptr == PTR_LOCAL_SECOND_LIMIT);
      sel.chan = CHAN_LOCAL;
    end
    else if (ptr >= PTR_REMOTE_FIRST_BASE && ptr <= PTR_REMOTE_LAST)
    begin
      sel.hit = (off[2:0] == SLOT_FIRST) || (off[2:0] == SLOT_SECOND);
      sel.second = (off[2:0] == SLOT_SECOND);
      sel.chan = {1'b0, off[5:3]} + 4'h1;
    end
    return sel;
  endfunction

  // Places channel flags in a status word: local at the local bit and
  // remote channel n just n places above it.
  function automatic logic [15:0] pack_status(input logic [8:0] flags);
    logic [15:0] word;
    word = ZERO_WORD;
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      word[STATUS_LOCAL_BIT + i] = flags[i];
    end
    return word;
  endfunction

  // --------------------------------------------------------------------
  // Internal state
  // --------------------------------------------------------------------
  logic [7:0] pointer;
  logic [15:0] hysteresis;
  logic [15:0] first_limit [NUM_CHAN];
  logic [15:0] second_limit [NUM_CHAN];
  logic [8:0] first_flags;
  logic [8:0] second_flags;
  logic [7:0] remote_open_circuit_flags;
  logic [15:0] software_reset_trigger;
  logic regs_clear;
  logic trigger_write;
  logic protected_write_ok;
  tas_limit_sel_type wr_sel;
  tas_limit_sel_type rd_sel;
  logic [8:0] conv_hit;
  logic [15:0] next_rd_data;
  logic [15:0] first_limit_status;
  logic [15:0] second_limit_status;
  logic [15:0] remote_open_circuit_status;

  // Readable views of the flag vectors, named as in the register map.
  logic [7:0] remote_first_limit_flags;
  logic local_first_limit_flag;
  logic [7:0] remote_second_limit_flags;
  logic local_second_limit_flag;

  assign remote_first_limit_flags = first_flags[8:1];
  assign local_first_limit_flag = first_flags[0];
  assign remote_second_limit_flags = second_flags[8:1];
  assign local_second_limit_flag = second_flags[0];

  // --------------------------------------------------------------------
  // Software reset
  // --------------------------------------------------------------------
  // A software reset clears the same state as the power-on reset but one
  // cycle after the write, so the write itself completes cleanly first.
  assign regs_clear = sys_rst | soft_reset_pulse;
  assign trigger_write = reg_wr && (pointer == PTR_SOFT_RESET)
    && reg_wr_data[RESET_TRIGGER_BIT];

  // The pulse flop itself only answers the power-on reset, otherwise the
  // pulse would cut itself short.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      soft_reset_pulse <= trigger_write && !lock_active;
    end
  end

  // The trigger bit never stays set, so the whole word reads as zero.
  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      software_reset_trigger <= SOFT_RESET_POR;
    end
    else
    begin
      software_reset_trigger <= SOFT_RESET_POR;
    end
  end

  // --------------------------------------------------------------------
  // Pointer register
  // --------------------------------------------------------------------
  // Every write transaction loads the pointer; reads use whatever value
  // the host left there last.
  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      pointer <= PTR_POR;
    end
    else if (ptr_wr)
    begin
      pointer <= ptr_data;
    end
  end

  // --------------------------------------------------------------------
  // Limit and hysteresis registers
  // --------------------------------------------------------------------
  // Lock protects these along with the reset trigger. Writes to status,
  // read-only or unassigned pointers fall through every branch.
  assign protected_write_ok = reg_wr && !lock_active;
  assign wr_sel = decode_limit(pointer);

  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      hysteresis <= HYSTERESIS_POR;
    end
    else if (protected_write_ok && pointer == PTR_HYSTERESIS)
    begin
      hysteresis <= reg_wr_data & HYSTERESIS_FIELD_MASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        first_limit[i] <= FIRST_LIMIT_POR;
        second_limit[i] <= SECOND_LIMIT_POR;
      end
    end
    else if (protected_write_ok && wr_sel.hit)
    begin
      if (wr_sel.second)
      begin
        second_limit[wr_sel.chan] <= reg_wr_data & LIMIT_FIELD_MASK;
      end
      else
      begin
        first_limit[wr_sel.chan] <= reg_wr_data & LIMIT_FIELD_MASK;
      end
    end
  end

  // --------------------------------------------------------------------
  // Limit comparators
  // --------------------------------------------------------------------
  // Each comparator wakes only when its own channel's result is stored,
  // so a limit change takes effect at that channel's next conversion.
  always_comb
  begin
    conv_hit = '0;
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      conv_hit[i] = conv_valid && (conv.chan == 4'(i));
    end
  end

  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    tas_limit_cell u_first
    (
      .mclk(mclk),
      .clear(regs_clear),
      .update(conv_hit[g]),
      .temp(conv.temp),
      .limit(first_limit[g]),
      .hysteresis(hysteresis),
      .flag(first_flags[g])
    );

    tas_limit_cell u_second
    (
      .mclk(mclk),
      .clear(regs_clear),
      .update(conv_hit[g]),
      .temp(conv.temp),
      .limit(second_limit[g]),
      .hysteresis(hysteresis),
      .flag(second_flags[g])
    );
  end

  // --------------------------------------------------------------------
  // Alarm outputs
  // --------------------------------------------------------------------
  // Alarms follow the flags alone; an open sensor only reaches them by
  // way of the bad reading it produces.
  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      first_alarm_out_n <= 1'b1;
      second_alarm_out_n <= 1'b1;
    end
    else
    begin
      first_alarm_out_n <= ~|first_flags;
      second_alarm_out_n <= ~|second_flags;
    end
  end

  // --------------------------------------------------------------------
  // Open-circuit flags
  // --------------------------------------------------------------------
  // Sampled every cycle so the status register shows the live detector.
  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      remote_open_circuit_flags <= '0;
    end
    else
    begin
      remote_open_circuit_flags <= open_detect;
    end
  end

  // --------------------------------------------------------------------
  // Status words
  // --------------------------------------------------------------------
  assign first_limit_status = pack_status(first_flags);
  assign second_limit_status = pack_status(second_flags);

  always_comb
  begin
    remote_open_circuit_status = ZERO_WORD;
    for (int i = 0; i < NUM_REMOTE; i++)
    begin
      remote_open_circuit_status[OPEN_REMOTE1_BIT + i] =
        remote_open_circuit_flags[i];
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Unassigned pointers still answer so the host transaction completes;
  // they return a fixed word rather than anything stale.
  assign rd_sel = decode_limit(pointer);

  always_comb
  begin
    next_rd_data = UNMAPPED_READ_VALUE;
    case (pointer)
      PTR_SOFT_RESET: next_rd_data = software_reset_trigger;
      PTR_FIRST_STATUS: next_rd_data = first_limit_status;
      PTR_SECOND_STATUS: next_rd_data = second_limit_status;
      PTR_OPEN_STATUS: next_rd_data = remote_open_circuit_status;
      PTR_HYSTERESIS: next_rd_data = hysteresis;
      default:
      begin
        if (rd_sel.hit)
        begin
          next_rd_data = rd_sel.second ? second_limit[rd_sel.chan]
            : first_limit[rd_sel.chan];
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (regs_clear)
    begin
      rd_data <= ZERO_WORD;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= reg_rd;
      if (reg_rd)
      begin
        rd_data <= next_rd_data;
      end
    end
  end

endmodule

// ### shared/tas_pkg.sv
// Package of constants and carrier types for the thermal alarm status block.
package tas_pkg;

  // --------------------------------------------------------------------
  // Pointer values of the register map
  // --------------------------------------------------------------------
  localparam logic [7:0] PTR_POR = 8'h00;
  localparam logic [7:0] PTR_SOFT_RESET = 8'h20;
  localparam logic [7:0] PTR_FIRST_STATUS = 8'h21;
  localparam logic [7:0] PTR_SECOND_STATUS = 8'h22;
  localparam logic [7:0] PTR_OPEN_STATUS = 8'h23;
  localparam logic [7:0] PTR_HYSTERESIS = 8'h38;
  localparam logic [7:0] PTR_LOCAL_FIRST_LIMIT = 8'h39;
  localparam logic [7:0] PTR_LOCAL_SECOND_LIMIT = 8'h3A;
  localparam logic [7:0] PTR_REMOTE_FIRST_BASE = 8'h42;
  localparam logic [7:0] PTR_REMOTE_LAST = 8'h7B;
  localparam logic [7:0] PTR_REMOTE_STRIDE = 8'h08;

  // --------------------------------------------------------------------
  // Channel counts and field positions
  // --------------------------------------------------------------------
  localparam int NUM_CHAN = 9;
  localparam int NUM_REMOTE = 8;
  localparam logic [3:0] CHAN_LOCAL = 4'h0;
  localparam int RESET_TRIGGER_BIT = 15;
  localparam int STATUS_LOCAL_BIT = 7;
  localparam int OPEN_REMOTE1_BIT = 8;
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_SECOND = 3'h1;

  // --------------------------------------------------------------------
  // Power-on values and writable field masks
  // --------------------------------------------------------------------
  localparam logic [15:0] SOFT_RESET_POR = 16'h0000;
  localparam logic [15:0] FIRST_LIMIT_POR = 16'h7FC0;
  localparam logic [15:0] SECOND_LIMIT_POR = 16'h7FC0;
  localparam logic [15:0] HYSTERESIS_POR = 16'h0000;
  localparam logic [15:0] LIMIT_FIELD_MASK = 16'hFFC0;
  localparam logic [15:0] HYSTERESIS_FIELD_MASK = 16'h7FC0;
  localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // --------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------
  // One stored conversion result for one channel.
  typedef struct packed {
    logic [3:0] chan;
    logic [15:0] temp;
  } tas_conv_type;

  // Result of decoding a pointer value against the limit registers.
  typedef struct packed {
    logic hit;
    logic second;
    logic [3:0] chan;
  } tas_limit_sel_type;

endpackage
